// >>> src/crc8_map.svh
// constants for the bit-serial crc-8 stream generator
// assumes inclusion by bare name from the package and design file
`ifndef CRC8_MAP_SVH
`define CRC8_MAP_SVH

`define CRC8_WIDTH 8
`define CRC8_INIT 8'h00
`define CRC8_MSB 7
`define CRC8_TAP_LO 4
`define CRC8_TAP_HI 5
`define CRC8_MSG_BYTES 5
`define CRC8_BIT_LAST 3'h7
`define CRC8_BYTE_LAST 3'h4
`define CRC8_FIFO_DEPTH 8

`endif

// >>> src/crc8_pkg.sv
// types shared by the crc-8 stream generator
// assumes crc8_map.svh is on the include path
package crc8_pkg;
    `include "crc8_map.svh"

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DATA,
        ST_CHECK
    } tx_state_t;

    typedef logic [`CRC8_WIDTH-1:0] crc_byte_t;
endpackage : crc8_pkg

// >>> src/crc8_stream_tx.sv
// sensor-side serialiser: five measurement bytes in, six-byte bit
// stream out (data msb first, then the crc-8 check byte).
// assumes all inputs synchronous to clk_sys_i; the sink may stall.
//
// Operation
// - clear check register before each message
// - compare each bit with register bit 7
// - equal: shift left, bit 0 gets zero
// - differ: shift, invert bits 4,5, bit0 one
// - one step per bit, msb first, in order
// - final register value is the check byte
// - send five data bytes then check byte
`timescale 1ns/1ns

// macros live in the guarded map; including it keeps this file standalone
`include "crc8_map.svh"

// ****************************************************************
// byte fifo
// ****************************************************************
module crc8_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    output logic [WIDTH-1:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic rd_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
    logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
    logic [AW:0] count_ff, nxt_count;
    logic full_ff, nxt_full;
    logic empty_ff, nxt_empty;
    logic push, pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : ptr_inc

    // full and empty are flops so both handshakes leave a register
    assign wr_ready_o = ~full_ff;
    assign rd_valid_o = ~empty_ff;
    assign rd_data_o = mem[rd_ptr_ff];

    always_comb begin
        push = wr_valid_i & ~full_ff;
        pop = rd_ready_i & ~empty_ff;
        nxt_wr_ptr = push ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
        nxt_rd_ptr = pop ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
        nxt_count = count_ff;
        if (push && !pop) begin
            nxt_count = count_ff + (AW+1)'(1);
        end else if (pop && !push) begin
            nxt_count = count_ff - (AW+1)'(1);
        end
        nxt_full = (nxt_count == (AW+1)'(DEPTH));
        nxt_empty = (nxt_count == '0);
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            full_ff <= 1'b0;
            empty_ff <= 1'b1;
        end else if (clk_en_i) begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
            full_ff <= nxt_full;
            empty_ff <= nxt_empty;
        end
    end

    // storage has no reset; only written slots are ever read
    always_ff @(posedge clk_sys_i) begin
        if (clk_en_i && push) begin
            mem[wr_ptr_ff] <= wr_data_i;
        end
    end
endmodule : crc8_byte_fifo

// ****************************************************************
// stream generator top
// ****************************************************************
module crc8_stream_tx
    import crc8_pkg::*;
#(
    parameter int FIFO_DEPTH = `CRC8_FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic [7:0] byte_data_i,
    input wire logic byte_valid_i,
    output logic byte_ready_o,
    output logic ser_bit_o,
    output logic ser_valid_o,
    output logic ser_last_o,
    input wire logic ser_ready_i,
    output logic [7:0] crc_value_o,
    output logic frame_done_o
);
    // ************************************************************
    // crc and counter helpers
    // ************************************************************
    // one crc step per bit, feedback into bits 0, 4 and 5
    function automatic crc_byte_t crc_step(input crc_byte_t c,
                                           input logic b);
        crc_byte_t n;
        n = {c[`CRC8_MSB-1:0], 1'b0};
        if (b != c[`CRC8_MSB]) begin
            n[`CRC8_TAP_LO] = ~n[`CRC8_TAP_LO];
            n[`CRC8_TAP_HI] = ~n[`CRC8_TAP_HI];
            n[0] = 1'b1;
        end
        crc_step = n;
    endfunction : crc_step

    // index of the next bit within the byte on the wire
    function automatic logic [2:0] bit_inc(input logic [2:0] n);
        bit_inc = n + 3'h1;
    endfunction : bit_inc

    // bit 0 of each byte is the last to go out
    function automatic logic is_last_bit(input logic [2:0] n);
        is_last_bit = (n == `CRC8_BIT_LAST);
    endfunction : is_last_bit

    // msb first: move the next bit up to the top
    function automatic logic [7:0] shift_up(input logic [7:0] s);
        shift_up = {s[6:0], 1'b0};
    endfunction : shift_up

    logic [7:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic fifo_wr_ready;

    // ************************************************************
    // input buffering
    // ************************************************************
    crc8_byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .wr_data_i(byte_data_i),
        .wr_valid_i(byte_valid_i),
        .wr_ready_o(fifo_wr_ready),
        .rd_data_o(fifo_data),
        .rd_valid_o(fifo_valid),
        .rd_ready_i(fifo_pop)
    );

    // ************************************************************
    // serialiser state
    // ************************************************************
    tx_state_t state_ff, nxt_state;
    crc_byte_t crc_ff, nxt_crc;
    logic [7:0] shreg_ff, nxt_shreg;
    logic [2:0] bitcnt_ff, nxt_bitcnt;
    logic [2:0] bytecnt_ff, nxt_bytecnt;
    logic bit_ff, nxt_bit;
    logic valid_ff, nxt_valid;
    logic last_ff, nxt_last;
    logic [7:0] crc_out_ff, nxt_crc_out;
    logic done_ff, nxt_done;
    logic in_ready_ff, nxt_in_ready;
    logic take;

    always_comb begin
        nxt_state = state_ff;
        nxt_crc = crc_ff;
        nxt_shreg = shreg_ff;
        nxt_bitcnt = bitcnt_ff;
        nxt_bytecnt = bytecnt_ff;
        nxt_bit = bit_ff;
        nxt_valid = valid_ff;
        nxt_last = last_ff;
        nxt_crc_out = crc_out_ff;
        nxt_done = 1'b0;
        nxt_in_ready = fifo_wr_ready;
        fifo_pop = 1'b0;
        take = valid_ff & ser_ready_i;
        case (state_ff)
            ST_IDLE: begin
                // cleared every idle cycle: no stale remainder survives
                nxt_crc = `CRC8_INIT;
                if (fifo_valid) begin
                    fifo_pop = 1'b1;
                    nxt_shreg = fifo_data;
                    nxt_bit = fifo_data[7];
                    nxt_valid = 1'b1;
                    nxt_bitcnt = '0;
                    nxt_bytecnt = '0;
                    nxt_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (take) begin
                    nxt_crc = crc_step(crc_ff, bit_ff);
                    if (!is_last_bit(bitcnt_ff)) begin
                        nxt_shreg = shift_up(shreg_ff);
                        nxt_bit = shreg_ff[6];
                        nxt_bitcnt = bit_inc(bitcnt_ff);
                    end else if (bytecnt_ff == `CRC8_BYTE_LAST) begin
                        // check byte follows the fifth data byte
                        nxt_shreg = crc_step(crc_ff, bit_ff);
                        nxt_bit = nxt_shreg[7];
                        nxt_bitcnt = '0;
                        nxt_state = ST_CHECK;
                    end else begin
                        nxt_bytecnt = bytecnt_ff + 3'h1;
                        nxt_bitcnt = '0;
                        nxt_valid = 1'b0;
                    end
                end
                // refill between bytes; stream pauses if fifo ran dry
                if (!valid_ff && fifo_valid) begin
                    fifo_pop = 1'b1;
                    nxt_shreg = fifo_data;
                    nxt_bit = fifo_data[7];
                    nxt_valid = 1'b1;
                end
            end
            ST_CHECK: begin
                // crc_ff keeps the final remainder while its bits go out
                nxt_last = is_last_bit(nxt_bitcnt);
                if (take) begin
                    if (is_last_bit(bitcnt_ff)) begin
                        nxt_valid = 1'b0;
                        nxt_last = 1'b0;
                        // publish only once the whole check byte has left
                        nxt_crc_out = crc_ff;
                        nxt_done = 1'b1;
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_shreg = shift_up(shreg_ff);
                        nxt_bit = shreg_ff[6];
                        nxt_bitcnt = bit_inc(bitcnt_ff);
                        nxt_last = is_last_bit(bit_inc(bitcnt_ff));
                    end
                end
            end
            default: begin
                // unreachable encoding: drop the frame, fall back to idle
                nxt_state = ST_IDLE;
                nxt_valid = 1'b0;
                nxt_last = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= ST_IDLE;
            crc_ff <= `CRC8_INIT;
            shreg_ff <= 8'h00;
            bitcnt_ff <= 3'h0;
            bytecnt_ff <= 3'h0;
            bit_ff <= 1'b0;
            valid_ff <= 1'b0;
            last_ff <= 1'b0;
            crc_out_ff <= 8'h00;
            done_ff <= 1'b0;
            in_ready_ff <= 1'b0;
        end else if (clk_en_i) begin
            state_ff <= nxt_state;
            crc_ff <= nxt_crc;
            shreg_ff <= nxt_shreg;
            bitcnt_ff <= nxt_bitcnt;
            bytecnt_ff <= nxt_bytecnt;
            bit_ff <= nxt_bit;
            valid_ff <= nxt_valid;
            last_ff <= nxt_last;
            crc_out_ff <= nxt_crc_out;
            done_ff <= nxt_done;
            in_ready_ff <= nxt_in_ready;
        end
    end

    // registered ready lags the fifo by one cycle; fifo still
    // refuses writes when full, so a write offered under a stale ready is dropped
    assign byte_ready_o = in_ready_ff;
    assign ser_bit_o = bit_ff;
    assign ser_valid_o = valid_ff;
    assign ser_last_o = last_ff;
    assign crc_value_o = crc_out_ff;
    assign frame_done_o = done_ff;
endmodule : crc8_stream_tx

// >>> tb/crc8_stream_chk.sv
// port assertions for the crc-8 stream generator
// assumes one clock domain, reset async active low
`timescale 1ns/1ns
module crc8_stream_chk (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic ser_bit_o,
    input wire logic ser_valid_o,
    input wire logic ser_last_o,
    input wire logic ser_ready_i,
    input wire logic [7:0] crc_value_o,
    input wire logic frame_done_o
);
    wire take = clk_en_i & ser_valid_o & ser_ready_i;
    default clocking dc @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);
    // ****
    // properties
    // ****
    a_bit_held: assert property (ser_valid_o && !take |=>
        ser_valid_o && $stable(ser_bit_o)) else $error("bit moved");
    a_last_valid: assert property (ser_last_o |-> ser_valid_o)
        else $error("last alone");
    a_done_follows: assert property (take && ser_last_o |=>
        frame_done_o && !ser_valid_o) else $error("no done");
    a_done_cause: assert property ($rose(frame_done_o) |->
        $past(take) && $past(ser_last_o)) else $error("stray done");
    a_crc_holds: assert property (!frame_done_o |->
        $stable(crc_value_o)) else $error("crc moved");
    a_done_pulse: assert property (frame_done_o && clk_en_i |=>
        !frame_done_o) else $error("long done");
    a_done_idle: assert property (frame_done_o |-> !ser_last_o)
        else $error("last at done");
    a_en_freeze: assert property (!clk_en_i |=> $stable(ser_bit_o)
        && $stable(ser_valid_o)) else $error("moved while off");
    c_frame: cover property (take && ser_last_o);
    c_stall: cover property (ser_valid_o && !ser_ready_i);
    c_off: cover property (!clk_en_i && ser_valid_o);
endmodule : crc8_stream_chk

bind crc8_stream_tx crc8_stream_chk u_crc8_stream_chk (.clk_sys_i,
    .rst_b_i, .clk_en_i, .ser_bit_o, .ser_valid_o, .ser_last_o,
    .ser_ready_i, .crc_value_o, .frame_done_o);

// >>> tb/crc8_sink_model.sv
// receiving end: takes stream bits, keeps the last 48, checks the crc
// assumes mode 0 ready, 1 random stalls, 2 stalled
`timescale 1ns/1ns
module crc8_sink_model (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic ser_bit_i,
    input wire logic ser_valid_i,
    input wire logic ser_last_i,
    input wire logic [1:0] mode_i,
    output logic ser_ready_o,
    output logic [47:0] frame_o,
    output logic frame_vld_o,
    output logic crc_bad_o
);
    logic [4:0] lfsr_ff;
    logic take;
    logic [7:0] crc_ff, nxt_crc;
    assign ser_ready_o = mode_i == 2'h0 || (mode_i == 2'h1 && lfsr_ff[0]);
    assign take = clk_en_i & ser_valid_i & ser_ready_o;
    // a good check byte drives the receiver's remainder back to zero
    assign nxt_crc = {crc_ff[6:0], 1'b0} ^
        ((ser_bit_i != crc_ff[7]) ? 8'h31 : 8'h00);
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lfsr_ff <= 5'h15;
            frame_o <= 48'h0;
            frame_vld_o <= 1'b0;
            crc_ff <= 8'h00;
            crc_bad_o <= 1'b0;
        end else begin
            lfsr_ff <= {lfsr_ff[3:0], lfsr_ff[4] ^ lfsr_ff[2]};
            frame_vld_o <= take & ser_last_i;
            if (take)
                frame_o <= {frame_o[46:0], ser_bit_i};
            if (take)
                crc_ff <= ser_last_i ? 8'h00 : nxt_crc;
            if (take && ser_last_i)
                crc_bad_o <= nxt_crc != 8'h00;
        end
    end
endmodule : crc8_sink_model

// >>> tb/crc8_stream_tx_tb.sv
// self-checking bench for the crc-8 stream generator
// assumes sink model and bound checker compiled alongside
`timescale 1ns/1ns
module crc8_stream_tx_tb;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [7:0] byte_data_i = 8'h00;
    logic byte_valid_i = 1'b0;
    logic [1:0] mode = 2'h0;
    logic en_rand = 1'b0;
    logic byte_ready_o, ser_bit_o, ser_valid_o, ser_last_o;
    logic ser_ready_i, frame_done_o, frame_vld, crc_bad;
    logic [7:0] crc_value_o;
    logic [47:0] frame;
    logic [47:0] exp_q[$];
    logic [7:0] byte_q[$];
    logic [39:0] m;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;

    crc8_stream_tx u_crc8_stream_tx (.clk_sys_i, .rst_b_i, .clk_en_i,
        .byte_data_i, .byte_valid_i, .byte_ready_o, .ser_bit_o,
        .ser_valid_o, .ser_last_o, .ser_ready_i, .crc_value_o,
        .frame_done_o);
    crc8_sink_model u_crc8_sink_model (.clk_sys_i, .rst_b_i, .clk_en_i,
        .ser_bit_i(ser_bit_o), .ser_valid_i(ser_valid_o),
        .ser_last_i(ser_last_o), .mode_i(mode), .ser_ready_o(ser_ready_i),
        .frame_o(frame), .frame_vld_o(frame_vld), .crc_bad_o(crc_bad));
    initial forever #4 clk_sys_i = ~clk_sys_i;

    function automatic logic [7:0] crc_of(input logic [39:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 39; i >= 0; i--)
            c = d[i] == c[7] ? {c[6:0], 1'b0} : {c[6:0], 1'b1} ^ 8'h30;
        return c;
    endfunction : crc_of

    task automatic check(input logic [47:0] seen, input logic [47:0] want);
        comparisons++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t: %h not %h", $time, seen, want);
        end
    endtask : check

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic hang;
        bad_count++;
        end_of_test();
    endtask : hang

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc > 50000)
            hang();
        if (frame_vld === 1'b1) begin
            check(frame, exp_q[0]);
            check(crc_value_o, exp_q[0][7:0]);
            check(frame_done_o, 1'b1);
            check(crc_bad, 1'b0);
            void'(exp_q.pop_front());
        end
        if (en_rand)
            clk_en_i <= $urandom % 4 != 0;
    end

    // two idle edges: ready lags the fifo's own full flag
    task automatic send_byte(input logic [7:0] b);
        for (int n = 0; byte_ready_o !== 1'b1; n++) begin
            if (n > 500)
                hang();
            @(posedge clk_sys_i);
        end
        byte_valid_i <= 1'b1;
        byte_data_i <= b;
        for (int n = 0; n == 0 || clk_en_i !== 1'b1; n++) begin
            if (n > 500)
                hang();
            @(posedge clk_sys_i);
        end
        byte_valid_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask : send_byte

    task automatic queue_frame(input logic [39:0] d);
        exp_q.push_back({d, crc_of(d)});
        for (int i = 4; i >= 0; i--)
            byte_q.push_back(d[i*8+:8]);
    endtask : queue_frame

    task automatic drain;
        while (byte_q.size() > 0)
            send_byte(byte_q.pop_front());
        for (int n = 0; exp_q.size() > 0; n++) begin
            if (n > 2000)
                hang();
            @(posedge clk_sys_i);
        end
    endtask : drain

    task automatic run(input logic [39:0] d, input string name);
        queue_frame(d);
        drain();
        $display("test %s done", name);
    endtask : run

    initial begin
        void'($urandom(79));
        repeat (8) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        run(40'h00_0000_0000, "zero");
        run(40'hff_ffff_ffff, "ones");
        run(40'h80_0000_0001, "edges");
        check(crc_of(40'h00_0000_0007), 8'h97);
        run(40'h00_0005_0931, "known");
        check(crc_value_o, 8'h58);
        mode <= 2'h1;
        en_rand <= 1'b1;
        repeat (6) begin
            m[39:32] = 8'($urandom);
            m[31:0] = $urandom;
            run(m, "random");
        end
        en_rand <= 1'b0;
        @(posedge clk_sys_i);
        clk_en_i <= 1'b1;
        mode <= 2'h2;
        queue_frame({$urandom, 8'h5a});
        queue_frame({8'ha5, $urandom});
        while (byte_ready_o === 1'b1 && byte_q.size() > 0)
            send_byte(byte_q.pop_front());
        check(byte_ready_o, 1'b0);
        mode <= 2'h1;
        drain();
        check(byte_ready_o, 1'b1);
        $display("test fill done");
        // source abandons a frame after three bytes, resets and sends afresh
        repeat (3)
            send_byte(8'($urandom));
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        check(byte_ready_o, 1'b0);
        check(ser_valid_o, 1'b0);
        check(frame_done_o, 1'b0);
        check(crc_value_o, 8'h00);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        m[39:32] = 8'($urandom);
        m[31:0] = $urandom;
        run(m, "retry");
        end_of_test();
    end
endmodule : crc8_stream_tx_tb
